// >>> shared/bds_pkg.sv
/*
 * Shared constants, enumerations and carrier structs of the bitstream
 * decryption and security block.
 * Assumes one configuration clock domain and a synchronous program-pin reset.
 */
package bds_pkg;

	// ---------------------------------------------------------------
	// sizes and counts
	// ---------------------------------------------------------------
	localparam int BDS_KEY_BITS = 256;
	localparam int BDS_BLOCK_BITS = 128;
	localparam int BDS_WORD_BITS = 32;
	localparam int BDS_KEY_WORDS = BDS_KEY_BITS / BDS_WORD_BITS;
	localparam int BDS_BLK_WORDS = BDS_BLOCK_BITS / BDS_WORD_BITS;
	localparam int BDS_FIFO_DEPTH = 32;
	localparam int BDS_ROUNDS = 14;
	localparam logic [2:0] BDS_KEY_LAST_IDX = 3'h7;
	localparam logic [2:0] BDS_BLK_LAST_IDX = 3'h3;
	localparam logic [2:0] BDS_IDX_ZERO = 3'h0;

	// ---------------------------------------------------------------
	// enumerations
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		BDS_PORT_SERIAL,
		BDS_PORT_JTAG,
		BDS_PORT_PARALLEL,
		BDS_PORT_INTERNAL
	} bds_port_t;

	typedef enum logic [1:0] {
		BDS_WIDTH_X1,
		BDS_WIDTH_X8,
		BDS_WIDTH_X16,
		BDS_WIDTH_X32
	} bds_width_t;

	typedef enum logic [2:0] {
		BDS_ST_IDLE,
		BDS_ST_LOAD,
		BDS_ST_DONE,
		BDS_ST_FAIL
	} bds_state_t;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		bds_port_t port;
		bds_width_t width;
		logic encrypted;
		logic partial;
		logic [BDS_WORD_BITS-1:0] key_tag;
	} bds_cfg_hdr_t;

	typedef struct packed {
		bds_state_t st;
		logic done;
		logic err;
		logic enc_cfg;
		logic key_acc;
		logic [2:0] wcnt;
		logic wait_ciph;
		logic go;
		logic [BDS_BLOCK_BITS-1:0] blk;
		logic unpack;
		logic [2:0] owords;
		logic [BDS_BLOCK_BITS-1:0] oblk;
		logic last_pend;
		logic cfg_ready;
		logic rb_grant;
		logic rb_deny;
		logic refused;
		logic init_oe;
	} bds_top_state_t;

	typedef struct packed {
		logic [BDS_KEY_BITS-1:0] key;
		logic [2:0] idx;
		logic valid;
	} bds_keymem_t;

endpackage

// >>> logic/bds_stream_fifo.sv
/*
 * Synchronous FIFO with a registered output word, valid and ready on both sides.
 * Assumes DEPTH is a power of two so that the pointers wrap on their own.
 */
module bds_stream_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 32
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
		logic ov;
		logic [W-1:0] od;
	} bds_fifo_state_t;

	bds_fifo_state_t cur_ff;
	bds_fifo_state_t nxt_cur;
	logic [W-1:0] mem [DEPTH];
	logic push;
	logic load;

	assign in_ready = cur_ff.cnt != FULL_CNT;
	assign out_valid = cur_ff.ov;
	assign out_data = cur_ff.od;
	assign push = in_valid && in_ready;
	// the output register refills from memory whenever a word is stored and it is empty or being taken
	assign load = (cur_ff.cnt != '0) && (!cur_ff.ov || out_ready);

	always_comb
	begin
		nxt_cur = cur_ff;
		if (push)
		begin
			nxt_cur.wr = cur_ff.wr + 1'b1;
		end
		if (load)
		begin
			nxt_cur.od = mem[cur_ff.rd];
			nxt_cur.ov = 1'b1;
			nxt_cur.rd = cur_ff.rd + 1'b1;
		end
		else if (out_ready)
		begin
			nxt_cur.ov = 1'b0;
		end
		case ({push, load})
			2'b10: nxt_cur.cnt = cur_ff.cnt + 1'b1;
			2'b01: nxt_cur.cnt = cur_ff.cnt - 1'b1;
			default: nxt_cur.cnt = cur_ff.cnt;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			cur_ff <= '0;
		end
		else
		begin
			cur_ff <= nxt_cur;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (push)
		begin
			mem[cur_ff.wr] <= in_data;
		end
	end

endmodule

// >>> logic/bds_block_unscramble.sv
/*
 * Iterative keyed block transform, one 128-bit block in flight at a time.
 * Assumes start is a one-cycle pulse given only while the core is idle.
 */
module bds_block_unscramble #(
	parameter int ROUNDS = bds_pkg::BDS_ROUNDS
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic start,
	input wire logic [bds_pkg::BDS_BLOCK_BITS-1:0] in_blk,
	input wire logic [bds_pkg::BDS_KEY_BITS-1:0] key,
	output logic done,
	output logic [bds_pkg::BDS_BLOCK_BITS-1:0] out_blk
);
	localparam int RW = $clog2(ROUNDS + 1);
	localparam logic [RW-1:0] LAST_RND = RW'(ROUNDS - 1);

	typedef struct packed {
		logic busy;
		logic [RW-1:0] rnd;
		logic done;
		logic [bds_pkg::BDS_BLOCK_BITS-1:0] x;
	} bds_ciph_state_t;

	bds_ciph_state_t cur_ff;
	bds_ciph_state_t nxt_cur;
	logic [bds_pkg::BDS_BLOCK_BITS-1:0] rkey;

	assign done = cur_ff.done;
	assign out_blk = cur_ff.x;
	// the two key halves alternate so each pair of rounds sees the full 256 bits
	assign rkey = cur_ff.rnd[0] ? key[bds_pkg::BDS_KEY_BITS-1:bds_pkg::BDS_BLOCK_BITS]
		: key[bds_pkg::BDS_BLOCK_BITS-1:0];

	always_comb
	begin
		nxt_cur = cur_ff;
		nxt_cur.done = 1'b0;
		if (!cur_ff.busy)
		begin
			if (start)
			begin
				nxt_cur.busy = 1'b1;
				nxt_cur.rnd = '0;
				nxt_cur.x = in_blk;
			end
		end
		else
		begin
			nxt_cur.x = {cur_ff.x[6:0], cur_ff.x[127:7]} ^ rkey ^ 128'(cur_ff.rnd);
			nxt_cur.rnd = cur_ff.rnd + 1'b1;
			if (cur_ff.rnd == LAST_RND)
			begin
				nxt_cur.busy = 1'b0;
				nxt_cur.done = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			cur_ff <= '0;
		end
		else
		begin
			cur_ff <= nxt_cur;
		end
	end

endmodule

// >>> logic/bds_security_ctrl.sv
/*
 * Bitstream decryption and configuration security control: key memory,
 * key-access mode, stream acceptance checks, block decryption, readback gating.
 * Assumes all inputs come from configuration logic on ref_clk; reset is the
 * program pin, already synchronised.
 */
module bds_security_ctrl #(
	parameter int FIFO_DEPTH = bds_pkg::BDS_FIFO_DEPTH,
	parameter int ROUNDS = bds_pkg::BDS_ROUNDS
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic key_load_instruction,
	input wire logic key_access_exit,
	input wire logic key_wr_valid,
	input wire bds_pkg::bds_port_t key_wr_port,
	input wire logic [bds_pkg::BDS_WORD_BITS-1:0] key_wr_data,
	input wire logic cfg_start,
	input wire bds_pkg::bds_cfg_hdr_t cfg_hdr,
	input wire logic cfg_valid,
	input wire logic [bds_pkg::BDS_WORD_BITS-1:0] cfg_data,
	input wire logic cfg_last,
	output logic cfg_ready,
	output logic m_valid,
	input wire logic m_ready,
	output logic [bds_pkg::BDS_WORD_BITS-1:0] m_data,
	input wire logic rb_req,
	input wire bds_pkg::bds_port_t rb_port,
	input wire logic rb_security_allow,
	output logic rb_grant,
	output logic rb_deny,
	input wire logic jtag_full_reprogram_instruction,
	input wire logic internal_reprogram_command,
	input wire logic fallback_request,
	output logic reconfig_refused,
	output logic done,
	output logic init_err_out,
	output logic init_err_oe
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	bds_pkg::bds_top_state_t cur_ff;
	bds_pkg::bds_top_state_t nxt_cur;
	bds_pkg::bds_keymem_t key_ff;
	bds_pkg::bds_keymem_t nxt_key;
	logic ciph_done;
	logic [bds_pkg::BDS_BLOCK_BITS-1:0] ciph_out;
	logic fifo_in_ready;
	logic take_word;
	logic hdr_bad;
	logic width_bad;
	logic port_bad;
	logic tag_match;
	logic restart;

	function automatic logic [bds_pkg::BDS_WORD_BITS-1:0] key_fold(
		input logic [bds_pkg::BDS_KEY_BITS-1:0] k
	);
		logic [bds_pkg::BDS_WORD_BITS-1:0] acc;
		acc = '0;
		for (int i = 0; i < bds_pkg::BDS_KEY_WORDS; i++)
		begin
			acc = acc ^ k[i*bds_pkg::BDS_WORD_BITS +: bds_pkg::BDS_WORD_BITS];
		end
		return acc;
	endfunction

	// only a one-way fold of the key is matched to the header tag; the full key feeds only the block transform
	assign tag_match = key_ff.valid && (key_fold(key_ff.key) == cfg_hdr.key_tag);
	assign width_bad = (cfg_hdr.width == bds_pkg::BDS_WIDTH_X16) || (cfg_hdr.width == bds_pkg::BDS_WIDTH_X32);
	// the internal port may read back, but it never carries an encrypted load
	assign port_bad = cfg_hdr.port == bds_pkg::BDS_PORT_INTERNAL;
	assign hdr_bad = cfg_hdr.encrypted && (width_bad || cfg_hdr.partial || port_bad);
	assign take_word = cfg_valid && cur_ff.cfg_ready;
	assign restart = internal_reprogram_command || fallback_request;

	// ---------------------------------------------------------------
	// key memory: kept across program-pin reset
	// ---------------------------------------------------------------
	always_comb
	begin
		nxt_key = key_ff;
		// clearing also drops key valid, which reopens the write window
		if (key_load_instruction)
		begin
			nxt_key = '0;
		end
		// writes only inside key-access mode and only from JTAG
		else if (cur_ff.key_acc && key_wr_valid && (key_wr_port == bds_pkg::BDS_PORT_JTAG)
			&& !key_ff.valid)
		begin
			nxt_key.key = {key_ff.key[bds_pkg::BDS_KEY_BITS-bds_pkg::BDS_WORD_BITS-1:0], key_wr_data};
			nxt_key.idx = key_ff.idx + 1'b1;
			if (key_ff.idx == bds_pkg::BDS_KEY_LAST_IDX)
			begin
				nxt_key.valid = 1'b1;
			end
		end
	end

	// no reset term: the key survives program pin and reprogramming
	always_ff @(posedge ref_clk)
	begin
		key_ff <= nxt_key;
	end

	// ---------------------------------------------------------------
	// configuration control
	// ---------------------------------------------------------------
	always_comb
	begin
		nxt_cur = cur_ff;
		nxt_cur.go = 1'b0;
		nxt_cur.rb_grant = 1'b0;
		nxt_cur.rb_deny = 1'b0;
		nxt_cur.refused = 1'b0;

		case (cur_ff.st)
			bds_pkg::BDS_ST_IDLE:
			begin
				// a start during key-access mode is dropped: the key may be incomplete
				if (cfg_start && !cur_ff.key_acc)
				begin
					nxt_cur.enc_cfg = cfg_hdr.encrypted;
					nxt_cur.wcnt = bds_pkg::BDS_IDX_ZERO;
					nxt_cur.last_pend = 1'b0;
					if (hdr_bad || (cfg_hdr.encrypted && !tag_match))
					begin
						nxt_cur.st = bds_pkg::BDS_ST_FAIL;
						nxt_cur.err = 1'b1;
					end
					else
					begin
						nxt_cur.st = bds_pkg::BDS_ST_LOAD;
					end
				end
			end
			bds_pkg::BDS_ST_LOAD:
			begin
				if (take_word)
				begin
					nxt_cur.last_pend = cfg_last;
					if (cur_ff.enc_cfg)
					begin
						// gather one block before the decryptor may start
						nxt_cur.blk = {cur_ff.blk[95:0], cfg_data};
						nxt_cur.wcnt = cur_ff.wcnt + 1'b1;
						if (cur_ff.wcnt == bds_pkg::BDS_BLK_LAST_IDX)
						begin
							nxt_cur.go = 1'b1;
							nxt_cur.wait_ciph = 1'b1;
							nxt_cur.wcnt = bds_pkg::BDS_IDX_ZERO;
						end
						else if (cfg_last)
						begin
							// a partial last block cannot be decrypted
							nxt_cur.st = bds_pkg::BDS_ST_FAIL;
							nxt_cur.err = 1'b1;
						end
					end
					else
					begin
						nxt_cur.oblk = {cfg_data, 96'h0};
						nxt_cur.owords = 3'h1;
						nxt_cur.unpack = 1'b1;
					end
				end
				// reprogram requests are refused while an encrypted stream loads
				if (restart && cur_ff.enc_cfg)
				begin
					nxt_cur.refused = 1'b1;
				end
				// the transform result waits in the unpacker until the FIFO takes it
				if (ciph_done)
				begin
					nxt_cur.oblk = ciph_out;
					nxt_cur.owords = 3'h4;
					nxt_cur.unpack = 1'b1;
					nxt_cur.wait_ciph = 1'b0;
				end
				if (cur_ff.unpack && fifo_in_ready)
				begin
					nxt_cur.oblk = {cur_ff.oblk[95:0], 32'h0};
					nxt_cur.owords = cur_ff.owords - 1'b1;
					if (cur_ff.owords == 3'h1)
					begin
						nxt_cur.unpack = 1'b0;
						if (cur_ff.last_pend)
						begin
							nxt_cur.st = bds_pkg::BDS_ST_DONE;
							nxt_cur.done = 1'b1;
						end
					end
				end
			end
			bds_pkg::BDS_ST_DONE:
			begin
				// an encrypted load pins the device here until reset, full reprogram or key load
				if ((cfg_start || restart) && cur_ff.enc_cfg)
				begin
					nxt_cur.refused = 1'b1;
				end
				else if (cfg_start || restart)
				begin
					nxt_cur.st = bds_pkg::BDS_ST_IDLE;
					nxt_cur.done = 1'b0;
				end
				if (rb_req)
				begin
					if (rb_port == bds_pkg::BDS_PORT_INTERNAL)
					begin
						nxt_cur.rb_grant = 1'b1;
					end
					else if ((rb_port == bds_pkg::BDS_PORT_JTAG || rb_port == bds_pkg::BDS_PORT_PARALLEL)
						&& !cur_ff.enc_cfg && rb_security_allow)
					begin
						nxt_cur.rb_grant = 1'b1;
					end
					else
					begin
						nxt_cur.rb_deny = 1'b1;
					end
				end
			end
			bds_pkg::BDS_ST_FAIL:
			begin
				// stays failed: only reset, full reprogram or key load leave this state
				if (cfg_start || restart)
				begin
					nxt_cur.refused = 1'b1;
				end
			end
			default:
			begin
				nxt_cur.st = bds_pkg::BDS_ST_IDLE;
			end
		endcase

		if (rb_req && (cur_ff.st != bds_pkg::BDS_ST_DONE))
		begin
			nxt_cur.rb_deny = 1'b1;
		end

		if (key_access_exit)
		begin
			nxt_cur.key_acc = 1'b0;
		end

		// full reprogram clears configuration but leaves key memory alone
		if (jtag_full_reprogram_instruction)
		begin
			nxt_cur = '0;
		end

		// key load wins over every other event of the same cycle except a program-pin reset
		if (key_load_instruction)
		begin
			nxt_cur = '0;
			nxt_cur.key_acc = 1'b1;
		end

		// worked out from the next state so both leave a flop without a cycle of lag
		nxt_cur.init_oe = nxt_cur.err;
		nxt_cur.cfg_ready = (nxt_cur.st == bds_pkg::BDS_ST_LOAD) && !nxt_cur.unpack
			&& !nxt_cur.wait_ciph && !nxt_cur.last_pend;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			cur_ff <= '0;
		end
		else
		begin
			cur_ff <= nxt_cur;
		end
	end

	// ---------------------------------------------------------------
	// datapath
	// ---------------------------------------------------------------
	// fed only from gathered stream words, never from user logic
	bds_block_unscramble #(
		.ROUNDS(ROUNDS)
	) u_ciph (
		.ref_clk(ref_clk),
		.reset(reset),
		.start(cur_ff.go),
		.in_blk(cur_ff.blk),
		.key(key_ff.key),
		.done(ciph_done),
		.out_blk(ciph_out)
	);

	// the unpacker stalls on a full FIFO, which in turn drops cfg_ready
	bds_stream_fifo #(
		.W(bds_pkg::BDS_WORD_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.reset(reset),
		.in_valid(cur_ff.unpack),
		.in_ready(fifo_in_ready),
		.in_data(cur_ff.oblk[127:96]),
		.out_valid(m_valid),
		.out_ready(m_ready),
		.out_data(m_data)
	);

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign cfg_ready = cur_ff.cfg_ready;
	assign rb_grant = cur_ff.rb_grant;
	assign rb_deny = cur_ff.rb_deny;
	assign reconfig_refused = cur_ff.refused;
	assign done = cur_ff.done;
	// open-drain: data stays low, the enable alone decides whether the pin is pulled
	assign init_err_out = 1'b0;
	assign init_err_oe = cur_ff.init_oe;

endmodule

// >>> verif/bds_security_ctrl_asserts.sv
/*
 * Concurrent checks on the ports of the security control block.
 * Assumes one clock domain and a synchronous active-high reset.
 */
module bds_sec_chk (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic key_load_instruction,
	input wire logic rb_req,
	input wire bds_pkg::bds_port_t rb_port,
	input wire logic rb_grant,
	input wire logic rb_deny,
	input wire logic m_valid,
	input wire logic m_ready,
	input wire logic [31:0] m_data,
	input wire logic jtag_full_reprogram_instruction,
	input wire logic internal_reprogram_command,
	input wire logic reconfig_refused,
	input wire logic cfg_ready,
	input wire logic done,
	input wire logic init_err_out,
	input wire logic init_err_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------
	// clocking
	// ------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	// ------
	// checks
	// ------
	pin_low_a: assert property (init_err_out == 1'b0)
		else $error("init pin data not low");
	err_blocks_done_a: assert property (init_err_oe |-> !done)
		else $error("done high with error");
	one_answer_a: assert property (!(rb_grant && rb_deny))
		else $error("grant and deny together");
	answer_cause_a: assert property ((rb_grant || rb_deny) |-> $past(rb_req))
		else $error("readback answer without request");
	internal_read_a: assert property (rb_req && rb_port == bds_pkg::BDS_PORT_INTERNAL && done |=> rb_grant)
		else $error("internal port readback not granted");
	reset_quiet_a: assert property ($past(reset) |-> !done && !cfg_ready && !init_err_oe)
		else $error("outputs active after reset");
	full_reprog_a: assert property (jtag_full_reprogram_instruction |=> !done && !init_err_oe)
		else $error("full reprogram did not clear");
	key_load_clear_a: assert property (key_load_instruction |=> !done && !init_err_oe && !cfg_ready)
		else $error("key load did not clear");
	reprog_gate_a: assert property (internal_reprogram_command && done |=> reconfig_refused || !done)
		else $error("reprogram neither refused nor taken");
	hold_out_a: assert property (m_valid && !m_ready |=> m_valid && $stable(m_data))
		else $error("output word dropped while stalled");
endmodule

bind bds_security_ctrl bds_sec_chk i_bds_sec_chk (
	.ref_clk(ref_clk), .reset(reset), .key_load_instruction(key_load_instruction),
	.rb_req(rb_req), .rb_port(rb_port), .rb_grant(rb_grant), .rb_deny(rb_deny),
	.m_valid(m_valid), .m_ready(m_ready), .m_data(m_data),
	.jtag_full_reprogram_instruction(jtag_full_reprogram_instruction),
	.internal_reprogram_command(internal_reprogram_command), .reconfig_refused(reconfig_refused),
	.cfg_ready(cfg_ready), .done(done), .init_err_out(init_err_out), .init_err_oe(init_err_oe)
);

// >>> verif/bds_cfg_source.sv
/*
 * Configuration stream source and stalling sink of the decrypted stream.
 * Assumes send is called just after a rising clock edge.
 */
module bds_cfg_source (
	input wire logic ref_clk,
	input wire logic cfg_ready,
	output bds_pkg::bds_cfg_hdr_t cfg_hdr,
	output logic cfg_start,
	output logic cfg_valid,
	output logic [31:0] cfg_data,
	output logic cfg_last,
	input wire logic m_valid,
	input wire logic [31:0] m_data,
	output logic m_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	int rx_count = 0;
	logic [31:0] rx_last = 32'h0;
	logic [1:0] ph = 2'h0;

	initial
	begin
		cfg_hdr = '0;
		cfg_start = 1'b0;
		cfg_valid = 1'b0;
		cfg_data = 32'h0;
		cfg_last = 1'b0;
	end

	// ------
	// source: word held until taken, same handshake plain or encrypted
	// ------
	task automatic send(input bds_pkg::bds_cfg_hdr_t h, input int n, input logic [31:0] base);
		cfg_hdr <= h;
		cfg_start <= 1'b1;
		@(posedge ref_clk);
		cfg_start <= 1'b0;
		for (int i = 0; i < n; i++)
		begin
			cfg_valid <= 1'b1;
			cfg_data <= base + i;
			cfg_last <= (i == n - 1);
			// each word stands until an edge samples ready high; a hang meets the bench's ceiling
			do
			begin
				@(posedge ref_clk);
			end
			while (cfg_ready !== 1'b1);
		end
		// released once per transfer, after the last word was taken
		cfg_valid <= 1'b0;
		cfg_last <= 1'b0;
		cfg_data <= ~base;
	endtask

	// ------
	// sink: ready half the time so the buffer backs up
	// ------
	assign m_ready = ph[1];
	always @(posedge ref_clk)
	begin
		ph <= ph + 2'h1;
		if (m_valid && m_ready)
		begin
			rx_count <= rx_count + 1;
			rx_last <= m_data;
		end
	end
endmodule

// >>> verif/bds_tb.sv
/*
 * Self-checking bench of the security control block.
 * Assumes the source model and the checker are compiled before it.
 */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic key_load_instruction = 1'b0;
	logic key_access_exit = 1'b0;
	logic key_wr_valid = 1'b0;
	bds_pkg::bds_port_t key_wr_port = bds_pkg::BDS_PORT_JTAG;
	logic [31:0] key_wr_data = 32'h0;
	logic rb_req = 1'b0;
	bds_pkg::bds_port_t rb_port = bds_pkg::BDS_PORT_JTAG;
	logic rb_security_allow = 1'b0;
	logic full_rp = 1'b0;
	logic int_rp = 1'b0;
	logic fb_req = 1'b0;
	bds_pkg::bds_cfg_hdr_t cfg_hdr;
	logic cfg_start, cfg_valid, cfg_last, cfg_ready, m_valid, m_ready;
	logic [31:0] cfg_data, m_data, tag;
	logic rb_grant, rb_deny, reconfig_refused, done, init_err_out, init_err_oe;
	logic [2:0] seen;
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;

	bds_security_ctrl i_bds_security_ctrl (
		.ref_clk(ref_clk), .reset(reset), .key_load_instruction(key_load_instruction),
		.key_access_exit(key_access_exit), .key_wr_valid(key_wr_valid), .key_wr_port(key_wr_port),
		.key_wr_data(key_wr_data), .cfg_start(cfg_start), .cfg_hdr(cfg_hdr), .cfg_valid(cfg_valid),
		.cfg_data(cfg_data), .cfg_last(cfg_last), .cfg_ready(cfg_ready), .m_valid(m_valid),
		.m_ready(m_ready), .m_data(m_data), .rb_req(rb_req), .rb_port(rb_port),
		.rb_security_allow(rb_security_allow), .rb_grant(rb_grant), .rb_deny(rb_deny),
		.jtag_full_reprogram_instruction(full_rp), .internal_reprogram_command(int_rp),
		.fallback_request(fb_req), .reconfig_refused(reconfig_refused), .done(done),
		.init_err_out(init_err_out), .init_err_oe(init_err_oe)
	);
	bds_cfg_source i_src (
		.ref_clk(ref_clk), .cfg_ready(cfg_ready), .cfg_hdr(cfg_hdr), .cfg_start(cfg_start),
		.cfg_valid(cfg_valid), .cfg_data(cfg_data), .cfg_last(cfg_last), .m_valid(m_valid),
		.m_data(m_data), .m_ready(m_ready)
	);

	initial
		forever #25 ref_clk = ~ref_clk;

	// ------
	// helpers
	// ------
	task automatic final_report;
		$display("checks %0d errors %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fail_count++;
			final_report();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	function automatic logic [31:0] kw(input int i);
		return 32'hC3A5_0000 + i * 32'h0001_0101;
	endfunction

	function automatic bds_pkg::bds_cfg_hdr_t mk(input bds_pkg::bds_port_t p, input bds_pkg::bds_width_t w,
		input logic e, input logic pt, input logic [31:0] k);
		mk = '{p, w, e, pt, k};
	endfunction

	// answers are pulses, so they are gathered over a few settled samples
	task automatic watch;
		seen = 3'h0;
		repeat (3)
		begin
			@(negedge ref_clk);
			seen = seen | {reconfig_refused, rb_deny, rb_grant};
		end
		@(posedge ref_clk);
	endtask

	task automatic rb(input bds_pkg::bds_port_t p, input logic al, input logic [2:0] exp);
		rb_port <= p;
		rb_security_allow <= al;
		rb_req <= 1'b1;
		@(posedge ref_clk);
		rb_req <= 1'b0;
		watch();
		chk("readback", {29'h0, exp}, {29'h0, seen});
	endtask

	task automatic reconf(input logic i, input logic f, input logic [2:0] exp);
		int_rp <= i;
		fb_req <= f;
		@(posedge ref_clk);
		int_rp <= 1'b0;
		fb_req <= 1'b0;
		watch();
		chk("reconfig", {29'h0, exp}, {29'h0, seen});
	endtask

	task automatic fr;
		full_rp <= 1'b1;
		@(posedge ref_clk);
		full_rp <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk("cleared done", 32'h0, {31'h0, done});
		chk("cleared err", 32'h0, {31'h0, init_err_oe});
	endtask

	task automatic wait_done;
		int t;
		t = 0;
		while (done !== 1'b1 && t < 200)
		begin
			@(posedge ref_clk);
			t++;
		end
		chk("done wait", 32'h1, {31'h0, done});
		repeat (20) @(posedge ref_clk);
	endtask

	// ------
	// scenarios
	// ------
	task automatic t_key;
		key_load_instruction <= 1'b1;
		@(posedge ref_clk);
		key_load_instruction <= 1'b0;
		key_wr_valid <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			key_wr_port <= bds_pkg::bds_port_t'(i[1:0]);
			key_wr_data <= (i == 1) ? kw(0) : 32'hFFFF_FFFF;
			@(posedge ref_clk);
		end
		key_wr_port <= bds_pkg::BDS_PORT_JTAG;
		for (int i = 1; i < 9; i++)
		begin
			key_wr_data <= (i < 8) ? kw(i) : 32'h0;
			@(posedge ref_clk);
		end
		key_wr_valid <= 1'b0;
		// a start while key-access mode is still open must be dropped
		i_src.send(mk(bds_pkg::BDS_PORT_SERIAL, bds_pkg::BDS_WIDTH_X1, 1'b0, 1'b0, 32'h0), 0, 32'h0);
		@(negedge ref_clk);
		chk("keymode start", 32'h0, {31'h0, cfg_ready});
		@(posedge ref_clk);
		key_access_exit <= 1'b1;
		@(posedge ref_clk);
		key_access_exit <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic t_plain;
		i_src.send(mk(bds_pkg::BDS_PORT_SERIAL, bds_pkg::BDS_WIDTH_X32, 1'b0, 1'b0, 32'h0), 1, 32'h1234_5678);
		wait_done();
		chk("plain word", 32'h1234_5678, i_src.rx_last);
		rb(bds_pkg::BDS_PORT_JTAG, 1'b1, 3'b001);
		rb(bds_pkg::BDS_PORT_PARALLEL, 1'b0, 3'b010);
		reconf(1'b1, 1'b0, 3'b000);
		chk("plain reload", 32'h0, {31'h0, done});
	endtask

	task automatic t_bad;
		bds_pkg::bds_cfg_hdr_t h [4];
		h[0] = mk(bds_pkg::BDS_PORT_JTAG, bds_pkg::BDS_WIDTH_X16, 1'b1, 1'b0, tag);
		h[1] = mk(bds_pkg::BDS_PORT_PARALLEL, bds_pkg::BDS_WIDTH_X32, 1'b1, 1'b0, tag);
		h[2] = mk(bds_pkg::BDS_PORT_PARALLEL, bds_pkg::BDS_WIDTH_X8, 1'b1, 1'b1, tag);
		h[3] = mk(bds_pkg::BDS_PORT_SERIAL, bds_pkg::BDS_WIDTH_X1, 1'b1, 1'b0, ~tag);
		foreach (h[i])
		begin
			i_src.send(h[i], 0, 32'h0);
			repeat (4) @(posedge ref_clk);
			chk("bad err", 32'h1, {31'h0, init_err_oe});
			chk("bad done", 32'h0, {31'h0, done});
			fr();
		end
	endtask

	task automatic t_enc;
		int n0;
		n0 = i_src.rx_count;
		i_src.send(mk(bds_pkg::BDS_PORT_JTAG, bds_pkg::BDS_WIDTH_X8, 1'b1, 1'b0, tag), 4, 32'h0BAD_F00D);
		wait_done();
		chk("enc done", 32'h1, {31'h0, done});
		chk("enc words", 32'h4, i_src.rx_count - n0);
		rb(bds_pkg::BDS_PORT_JTAG, 1'b1, 3'b010);
		rb(bds_pkg::BDS_PORT_PARALLEL, 1'b1, 3'b010);
		rb(bds_pkg::BDS_PORT_INTERNAL, 1'b0, 3'b001);
		reconf(1'b1, 1'b0, 3'b100);
		reconf(1'b0, 1'b1, 3'b100);
		i_src.send(mk(bds_pkg::BDS_PORT_SERIAL, bds_pkg::BDS_WIDTH_X1, 1'b0, 1'b0, 32'h0), 0, 32'h0);
		watch();
		chk("restart", 32'h4, {29'h0, seen});
		chk("done kept", 32'h1, {31'h0, done});
	endtask

	initial
	begin
		tag = 32'h0;
		for (int i = 0; i < 8; i++)
			tag = tag ^ kw(i);
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		t_key();
		t_plain();
		t_bad();
		t_enc();
		reset <= 1'b1;
		@(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		t_enc();
		fr();
		final_report();
	end
endmodule
